// [logic/gpp_pkg.sv]
/*
 gpp_pkg: constants and carrier types for the eight-pad general-purpose port.
 Assumes one main clock; the port's registers are reached through a plain
 byte-wide write/read port with no public bus around it.
*/
// Operation
// - after reset pads are port-owned, driver off, input buffer on
// - pad n configuration byte sits at offset 0x10 plus n
// - drive-enable bit one drives pad n, zero makes it an input
// - set alias ones set drive-enable bits, zeros ignored
// - clear alias ones clear drive-enable bits only
// - toggle alias ones invert drive-enable bits only
// - value set alias ones set output-value bits
// - value clear alias ones clear output-value bits
// - toggle alias or input register ones invert output-value bits
// - input register shows synced pad only when input not disabled
// - polarity flip inverts both driven and read values
// - changing polarity flip gives a visible internal edge
// - bias-up bit switches on pad pull-up
// - sense config selects both, rising, falling, low level or disabled
// - sense hit sets flag; request held while any enabled flag set
// - clock stopped: sync pads wake only on both-edge or level
// - sync pads need one-cycle pulse, three-cycle dead time
// - event output equals pad value when input enabled, else zero
// - bit-access mirrors write exactly like the regular registers
// - enabled peripheral overrides its pad; others stay ordinary
// - port runs on main clock; sync stops when clock stops
// - pad input synchronised; synchroniser frozen when input disabled
// - driving a pad keeps its input path readable
// - reading drive-enable aliases returns drive-enable register
package gpp_pkg;
    localparam int PADS = 8;
    // register offsets
    localparam logic [4:0] OFS_DRIVE_ENABLE = 5'h00;
    localparam logic [4:0] OFS_DRIVE_ENABLE_SET = 5'h01;
    localparam logic [4:0] OFS_DRIVE_ENABLE_CLEAR = 5'h02;
    localparam logic [4:0] OFS_DRIVE_ENABLE_TOGGLE = 5'h03;
    localparam logic [4:0] OFS_DRIVE_VALUE = 5'h04;
    localparam logic [4:0] OFS_DRIVE_VALUE_SET = 5'h05;
    localparam logic [4:0] OFS_DRIVE_VALUE_CLEAR = 5'h06;
    localparam logic [4:0] OFS_DRIVE_VALUE_TOGGLE = 5'h07;
    localparam logic [4:0] OFS_INPUT_VALUE = 5'h08;
    localparam logic [4:0] OFS_SENSE_FLAG = 5'h09;
    localparam logic [4:0] OFS_PAD_CONFIG_BASE = 5'h10;
    // per-pad config fields
    localparam int CFG_FLIP_BIT = 7;
    localparam int CFG_BIAS_BIT = 3;
    localparam int CFG_SENSE_LSB = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h8F;
    // dead time after a synchronous sense hit, in cycles
    localparam logic [1:0] DEAD_CYCLES = 2'h3;

    typedef enum logic [2:0]
    {
        SENSE_INTDISABLE = 3'h0,
        SENSE_DUAL_EDGE = 3'h1,
        SENSE_RISING = 3'h2,
        SENSE_FALLING = 3'h3,
        SENSE_INPUT_DISABLE = 3'h4,
        SENSE_LEVEL = 3'h5
    } gpp_sense_t;

    typedef struct packed
    {
        logic flip;
        logic bias_up;
        logic [2:0] sense;
    } gpp_cfg_t;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic mirror;
        logic [4:0] addr;
        logic [7:0] wdata;
    } gpp_req_t;
endpackage

// [logic/gpp_pad_sense.sv]
/*
 gpp_pad_sense: one pad's input synchroniser and sense detector.
 Assumes the pad level is asynchronous to mclk_in and that the parent
 supplies the pad's polarity and sense configuration from registers.
*/
`timescale 1ns/1ps
module gpp_pad_sense
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic pad_in,
    input wire logic flip_in,
    input wire logic [2:0] sense_in,
    output logic level_out,
    output logic hit_out
);
    import gpp_pkg::*;

    logic sync_a;
    logic sync_b;
    logic prev;
    logic [1:0] dead;
    logic in_on;
    logic seen;
    logic cond;

    assign in_on = (sense_in != 3'(SENSE_INPUT_DISABLE));
    // polarity applied after the flops so a flip change is an edge at once
    // read inversion
    assign seen = sync_b ^ flip_in;
    assign level_out = seen;

    // two-flop synchroniser, held still while the input is disabled
    // gated synchroniser
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end
        else if (clk_en_in && in_on)
        begin
            sync_a <= pad_in;
            sync_b <= sync_a;
        end
    end

    // previous seen level for edge compare
    // flip edge visible
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            prev <= 1'b0;
        else if (clk_en_in)
            prev <= seen;
    end

    always_comb
    begin
        unique case (sense_in)
            3'(SENSE_DUAL_EDGE): cond = seen ^ prev;
            3'(SENSE_RISING): cond = seen & ~prev;
            3'(SENSE_FALLING): cond = ~seen & prev;
            3'(SENSE_LEVEL): cond = ~seen;
            default: cond = 1'b0;
        endcase
    end

    assign hit_out = cond && (dead == 2'h0);

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            dead <= 2'h0;
        else if (clk_en_in)
        begin
            if (hit_out)
                dead <= DEAD_CYCLES;
            else if (dead != 2'h0)
                dead <= dead - 2'h1;
        end
    end
endmodule

// [logic/gpp_port.sv]
/*
 gpp_port: eight-pad general-purpose port with set/clear/toggle aliases,
 per-pad configuration, sense flags, wake and event outputs, and override.
 Assumes a single main clock, a byte-wide register port from the CPU side,
 and peripherals presenting their own override enable, drive and value.
*/
`timescale 1ns/1ps
module gpp_port
#(
    parameter int PAD_COUNT = 8,
    parameter logic [7:0] FULL_ASYNC_PADS = 8'h04
)
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire gpp_pkg::gpp_req_t req_in,
    output logic [7:0] rdata_out,
    input wire logic [PAD_COUNT-1:0] pad_in,
    output logic [PAD_COUNT-1:0] pad_out,
    output logic [PAD_COUNT-1:0] pad_oe_out,
    output logic [PAD_COUNT-1:0] pad_pullup_out,
    output logic [PAD_COUNT-1:0] pad_input_en_out,
    input wire logic [PAD_COUNT-1:0] periph_override_in,
    input wire logic [PAD_COUNT-1:0] periph_oe_in,
    input wire logic [PAD_COUNT-1:0] periph_value_in,
    output logic [PAD_COUNT-1:0] periph_level_out,
    input wire logic clock_stopped_in,
    output logic [PAD_COUNT-1:0] event_out,
    output logic irq_out,
    output logic wake_out
);
    import gpp_pkg::*;

    logic [PAD_COUNT-1:0] drive_enable;
    logic [PAD_COUNT-1:0] drive_value;
    logic [PAD_COUNT-1:0] sense_flag_reg;
    logic [7:0] per_pad_config_reg [PAD_COUNT];
    logic [PAD_COUNT-1:0] level;
    logic [PAD_COUNT-1:0] hit;
    logic [PAD_COUNT-1:0] flip;
    logic [PAD_COUNT-1:0] irq_en;
    logic [PAD_COUNT-1:0] wake_src;
    logic [PAD_COUNT-1:0] wd;
    logic [2:0] sense [PAD_COUNT];
    logic wr;
    logic [7:0] next_rdata;

    // mirror writes decode the same address space as regular ones
    // mirror behaves identically
    assign wr = req_in.wr && clk_en_in;
    assign wd = req_in.wdata[PAD_COUNT-1:0];

    // drive-enable register and its aliases
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            drive_enable <= '0;
        else if (wr)
        begin
            unique case (req_in.addr)
                OFS_DRIVE_ENABLE: drive_enable <= wd;
                OFS_DRIVE_ENABLE_SET: drive_enable <= drive_enable | wd;
                OFS_DRIVE_ENABLE_CLEAR: drive_enable <= drive_enable & ~wd;
                OFS_DRIVE_ENABLE_TOGGLE: drive_enable <= drive_enable ^ wd;
                default: drive_enable <= drive_enable;
            endcase
        end
    end

    // output-value register and its aliases
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            drive_value <= '0;
        else if (wr)
        begin
            unique case (req_in.addr)
                OFS_DRIVE_VALUE: drive_value <= wd;
                OFS_DRIVE_VALUE_SET: drive_value <= drive_value | wd;
                OFS_DRIVE_VALUE_CLEAR: drive_value <= drive_value & ~wd;
                OFS_DRIVE_VALUE_TOGGLE, OFS_INPUT_VALUE: drive_value <= drive_value ^ wd;
                default: drive_value <= drive_value;
            endcase
        end
    end

    // per-pad configuration bytes, unused bits stored as zero
    genvar n;
    generate
        for (n = 0; n < PAD_COUNT; n++)
        begin : g_pad
            always_ff @(posedge mclk_in)
            begin
                if (reset_in)
                    per_pad_config_reg[n] <= CFG_RESET;
                else if (wr && req_in.addr == OFS_PAD_CONFIG_BASE + 5'(n))
                    per_pad_config_reg[n] <= req_in.wdata & CFG_WRITE_MASK;
            end

            assign flip[n] = per_pad_config_reg[n][CFG_FLIP_BIT];
            // sense field picked once, so every user agrees on its position
            assign sense[n] = per_pad_config_reg[n][CFG_SENSE_LSB +: 3];
            assign irq_en[n] = (sense[n] != 3'(SENSE_INTDISABLE))
                && (sense[n] != 3'(SENSE_INPUT_DISABLE));
            assign pad_pullup_out[n] = per_pad_config_reg[n][CFG_BIAS_BIT];
            assign pad_input_en_out[n] = sense[n] != 3'(SENSE_INPUT_DISABLE);

            gpp_pad_sense u_sense
            (
                .mclk_in(mclk_in),
                .reset_in(reset_in),
                .clk_en_in(clk_en_in),
                .pad_in(pad_in[n]),
                .flip_in(flip[n]),
                .sense_in(sense[n]),
                .level_out(level[n]),
                .hit_out(hit[n])
            );

            assign wake_src[n] = FULL_ASYNC_PADS[n]
                ? (irq_en[n] && hit[n])
                : (hit[n] && (!clock_stopped_in
                   || sense[n] == 3'(SENSE_DUAL_EDGE)
                   || sense[n] == 3'(SENSE_LEVEL)));
        end
    endgenerate

    // sense flags: hardware set wins over a same-cycle clear
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            sense_flag_reg <= '0;
        else if (clk_en_in)
        begin
            if (req_in.wr && req_in.addr == OFS_SENSE_FLAG)
                sense_flag_reg <= (sense_flag_reg & ~wd) | hit;
            else
                sense_flag_reg <= sense_flag_reg | hit;
        end
    end

    assign irq_out = |(sense_flag_reg & irq_en);
    assign wake_out = |wake_src;

    // pad drivers; override takes enable and value from the peripheral, port polarity flip still applied
    // peripheral override
    assign pad_oe_out = (periph_override_in & periph_oe_in)
        | (~periph_override_in & drive_enable);
    assign pad_out = ((periph_override_in & periph_value_in)
        | (~periph_override_in & drive_value)) ^ flip;
    assign periph_level_out = level & pad_input_en_out;
    // event follows pad while input on
    assign event_out = level & pad_input_en_out;

    // read mux; aliases read back their base register
    always_comb
    begin
        next_rdata = REG_RESET;
        unique case (req_in.addr)
            OFS_DRIVE_ENABLE, OFS_DRIVE_ENABLE_SET, OFS_DRIVE_ENABLE_CLEAR,
            OFS_DRIVE_ENABLE_TOGGLE: next_rdata = 8'(drive_enable);
            OFS_DRIVE_VALUE, OFS_DRIVE_VALUE_SET, OFS_DRIVE_VALUE_CLEAR,
            OFS_DRIVE_VALUE_TOGGLE: next_rdata = 8'(drive_value);
            // input shows synced level if enabled
            OFS_INPUT_VALUE: next_rdata = 8'(level & pad_input_en_out);
            OFS_SENSE_FLAG: next_rdata = 8'(sense_flag_reg);
            default:
            begin
                for (int i = 0; i < PAD_COUNT; i++)
                begin
                    if (req_in.addr == OFS_PAD_CONFIG_BASE + 5'(i))
                        next_rdata = per_pad_config_reg[i];
                end
            end
        endcase
    end

    // registered read data, one cycle after the read strobe
    // single main clock
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
            rdata_out <= REG_RESET;
        else if (clk_en_in && req_in.rd)
            rdata_out <= next_rdata;
    end
endmodule

// [tb/gpp_port_props.sv]
/* gpp_port_props: port-level checks of gpp_port.
 Assumes it is bound to gpp_port and sees one clock domain. */
`timescale 1ns/1ps
module gpp_port_props
import gpp_pkg::*;
#(parameter int PAD_COUNT = 8)
(
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire gpp_pkg::gpp_req_t req_in,
    input wire logic [7:0] rdata_out,
    input wire logic [PAD_COUNT-1:0] pad_oe_out,
    input wire logic [PAD_COUNT-1:0] pad_input_en_out,
    input wire logic [PAD_COUNT-1:0] periph_override_in,
    input wire logic [PAD_COUNT-1:0] periph_oe_in,
    input wire logic [PAD_COUNT-1:0] periph_level_out,
    input wire logic [PAD_COUNT-1:0] event_out,
    input wire logic irq_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // a taken write, then a cycle with no override in the way
    sequence s_de(logic [4:0] ofs);
        clk_en_in && req_in.wr && req_in.addr == ofs && periph_override_in == '0
        ##1 periph_override_in == '0;
    endsequence
    // a frozen cycle, then one more with no override to blur the drivers
    sequence s_frozen;
        !clk_en_in && periph_override_in == '0 ##1 periph_override_in == '0;
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) reset_in && clk_en_in |=>
        (pad_oe_out & ~periph_override_in) == '0 && !irq_out)
        else $error("drivers on after reset");
    a_de_write: assert property (s_de(OFS_DRIVE_ENABLE) |-> pad_oe_out == $past(req_in.wdata))
        else $error("drive enable write lost");
    a_de_set: assert property (s_de(OFS_DRIVE_ENABLE_SET) |->
        pad_oe_out == ($past(pad_oe_out) | $past(req_in.wdata))) else $error("set alias wrong");
    a_de_clear: assert property (s_de(OFS_DRIVE_ENABLE_CLEAR) |->
        pad_oe_out == ($past(pad_oe_out) & ~$past(req_in.wdata))) else $error("clear alias wrong");
    a_de_toggle: assert property (s_de(OFS_DRIVE_ENABLE_TOGGLE) |->
        pad_oe_out == ($past(pad_oe_out) ^ $past(req_in.wdata))) else $error("toggle alias wrong");
    a_alias_read: assert property (clk_en_in && req_in.rd && !req_in.wr &&
        req_in.addr inside {[5'h01:5'h03]} && periph_override_in == '0
        |=> rdata_out == $past(pad_oe_out)) else $error("alias read wrong");
    a_rdata_hold: assert property (!(clk_en_in && req_in.rd) |=> $stable(rdata_out))
        else $error("read data moved");
    a_override_oe: assert property ((pad_oe_out & periph_override_in) ==
        (periph_oe_in & periph_override_in)) else $error("override ignored");
    a_event_gate: assert property (event_out == periph_level_out &&
        (event_out & ~pad_input_en_out) == '0) else $error("event not gated");
    a_freeze_hold: assert property (s_frozen |->
        $stable(pad_oe_out) && $stable(irq_out)) else $error("state moved while frozen");
endmodule
bind gpp_port gpp_port_props #(.PAD_COUNT(PAD_COUNT)) i_props (.mclk_in(mclk_in),
    .reset_in(reset_in), .clk_en_in(clk_en_in), .req_in(req_in), .rdata_out(rdata_out),
    .pad_oe_out(pad_oe_out), .pad_input_en_out(pad_input_en_out),
    .periph_override_in(periph_override_in), .periph_oe_in(periph_oe_in),
    .periph_level_out(periph_level_out), .event_out(event_out), .irq_out(irq_out));

// [tb/gpp_pad_model.sv]
/* gpp_pad_model: the pads and the outside drivers of gpp_port.
 Assumes the bench sets which pads are driven from outside, and to what. */
`timescale 1ns/1ps
module gpp_pad_model
(
    input wire logic mclk_in,
    input wire logic [7:0] drv_in,
    input wire logic [7:0] oe_in,
    input wire logic [7:0] pullup_in,
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    output logic [7:0] level_out
);
    logic [7:0] churn = 8'h5A;
    // floating pads wander, so no stale level passes for a real one
    always_ff @(posedge mclk_in)
        churn <= ~churn;
    // outside level held for as long as the bench asks
    assign level_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in)
        | (~oe_in & ~ext_en_in & (pullup_in | churn));
endmodule

// [tb/tb_gpp_port.sv]
/* tb_gpp_port: self-checking bench of gpp_port with random alias traffic.
 Assumes the checker is bound and the pad model closes the pad loop. */
`timescale 1ns/1ps
module tb_gpp_port;
    import gpp_pkg::*;
    logic mclk_in, reset_in, clk_en_in, clock_stopped_in, irq_out, wake_out;
    gpp_req_t req_in;
    logic [7:0] rdata_out, pad_in, pad_out, pad_oe_out, pad_pullup_out, pad_input_en_out;
    logic [7:0] periph_override_in, periph_oe_in, periph_value_in, periph_level_out, event_out;
    logic [7:0] ext_en, ext_val, de, dv, v;
    logic [7:0] modes [5] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h00};
    logic [4:0] want = 5'b01101;
    int num_errors, cmp_count, cycles, k, wakes;
    gpp_port i_dut (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
        .req_in(req_in), .rdata_out(rdata_out), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_out(pad_oe_out), .pad_pullup_out(pad_pullup_out),
        .pad_input_en_out(pad_input_en_out), .periph_override_in(periph_override_in),
        .periph_oe_in(periph_oe_in), .periph_value_in(periph_value_in),
        .periph_level_out(periph_level_out), .clock_stopped_in(clock_stopped_in),
        .event_out(event_out), .irq_out(irq_out), .wake_out(wake_out));
    gpp_pad_model i_pads (.mclk_in(mclk_in), .drv_in(pad_out), .oe_in(pad_oe_out),
        .pullup_in(pad_pullup_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .level_out(pad_in));
    initial
    begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, well above the run length
    always @(posedge mclk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            complete_run();
        end
    end
    // wake comes from one-cycle hits, so count it where it has settled
    always @(negedge mclk_in)
    begin
        if (wake_out === 1'b1)
            wakes++;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one strobe cycle, then settle past the edge that takes it
    task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        req_in <= '{w, ~w, 1'($urandom), a, d};
        @(posedge mclk_in);
        req_in <= '0;
        #1;
    endtask
    // plain write, set, clear, toggle
    function automatic logic [7:0] apply(int m, logic [7:0] r, logic [7:0] d);
        return m == 0 ? d : m == 1 ? r | d : m == 2 ? r & ~d : r ^ d;
    endfunction
    initial
    begin
        {reset_in, clk_en_in, clock_stopped_in} = 3'b110;
        {req_in, ext_en, ext_val, de, dv} = '0;
        {periph_override_in, periph_oe_in, periph_value_in} = '0;
        v = $urandom(51);
        repeat (10) @(posedge mclk_in);
        reset_in <= 1'b0;
        #1 chk(pad_oe_out, 8'h00);
        chk(pad_input_en_out, 8'hFF);
        for (int i = 0; i < 40; i++)
        begin
            v = (i == 0) ? 8'hFF : 8'($urandom);
            k = $urandom % 4;
            op(1'b1, 5'(k), v);
            de = apply(k, de, v);
            chk(pad_oe_out, de);
            op(1'b0, 5'($urandom % 4), 8'h00);
            chk(rdata_out, de);
            k = $urandom % 5;
            v = 8'($urandom);
            op(1'b1, 5'(4 + k), v);
            dv = apply(k == 4 ? 3 : k, dv, v);
            op(1'b0, OFS_DRIVE_VALUE, 8'h00);
            chk(rdata_out, dv);
        end
        op(1'b1, OFS_DRIVE_ENABLE, 8'hFF);
        // newly driven pads need the synchroniser latency before a read
        repeat (2) @(posedge mclk_in);
        op(1'b0, OFS_INPUT_VALUE, 8'h00);
        chk(rdata_out, dv);
        for (int n = 0; n < 8; n++)
            op(1'b1, OFS_PAD_CONFIG_BASE + 5'(n), n % 2 ? 8'h08 : 8'h00);
        chk(pad_pullup_out, 8'hAA);
        op(1'b1, 5'h10, 8'h80);
        chk(pad_out, dv ^ 8'h01);
        repeat (2) @(posedge mclk_in);
        op(1'b0, OFS_INPUT_VALUE, 8'h00);
        chk(rdata_out, dv);
        op(1'b1, 5'h10, 8'h00);
        op(1'b1, 5'h11, 8'h04);
        chk(pad_input_en_out, 8'hFD);
        chk(event_out, dv & 8'hFD);
        op(1'b0, OFS_INPUT_VALUE, 8'h00);
        chk(rdata_out, dv & 8'hFD);
        op(1'b0, 5'h11, 8'h00);
        chk(rdata_out, 8'h04);
        // pad 3 turned input, held high from outside
        op(1'b1, OFS_DRIVE_ENABLE_CLEAR, 8'h08);
        de = 8'hF7;
        {ext_en, ext_val} <= 16'h0808;
        op(1'b1, OFS_SENSE_FLAG, 8'hFF);
        for (int m = 0; m < 5; m++)
        begin
            op(1'b1, 5'h13, modes[m]);
            ext_val <= 8'h00;
            repeat (6) @(posedge mclk_in);
            #1 chk({7'h00, irq_out}, {7'h00, want[m]});
            op(1'b1, 5'h13, 8'h00);
            ext_val <= 8'h08;
            op(1'b1, OFS_SENSE_FLAG, 8'hF7);
            op(1'b0, OFS_SENSE_FLAG, 8'h00);
            chk(rdata_out & 8'h08, want[m] ? 8'h08 : 8'h00);
            op(1'b1, OFS_SENSE_FLAG, 8'hFF);
            op(1'b0, OFS_SENSE_FLAG, 8'h00);
            chk(rdata_out, 8'h00);
        end
        ext_val <= 8'h00;
        op(1'b1, 5'h13, 8'h02);
        op(1'b1, 5'h13, 8'h82);
        repeat (6) @(posedge mclk_in);
        #1 chk({7'h00, irq_out}, 8'h01);
        // pad 3 is sync-sensed: with the clock stopped only dual edge or level wakes
        clock_stopped_in <= 1'b1;
        k = wakes;
        op(1'b1, 5'h13, 8'h02);
        op(1'b1, 5'h13, 8'h82);
        repeat (3) @(posedge mclk_in);
        #1 chk(8'(wakes - k), 8'h00);
        op(1'b1, 5'h13, 8'h81);
        op(1'b1, 5'h13, 8'h01);
        repeat (3) @(posedge mclk_in);
        #1 chk(8'(wakes - k), 8'h01);
        clock_stopped_in <= 1'b0;
        v = 8'($urandom);
        periph_override_in <= 8'h20;
        {periph_oe_in, periph_value_in} <= {v, ~v};
        @(posedge mclk_in);
        #1 chk(pad_oe_out, (de & 8'hDF) | (v & 8'h20));
        chk(pad_out & 8'h20, ~v & 8'h20);
        periph_override_in <= 8'h00;
        clk_en_in <= 1'b0;
        op(1'b1, OFS_DRIVE_ENABLE, 8'h00);
        chk(pad_oe_out, de);
        clk_en_in <= 1'b1;
        complete_run();
    end
endmodule
